// ---- design/lzc_pkg.sv ----
// Constants, state encoding and field widths shared by the LZW string-table codec.
// Assumes one synchronous clock and a synchronous active-low reset in every user.

`default_nettype none

package lzc_pkg;

  localparam int SYM_W = 8;
  localparam int CODE_W = 10;
  localparam int ACC_W = 18;
  localparam int TBL_DEPTH = 1024;
  localparam int STK_DEPTH = 1024;

  localparam logic [3:0] CW_MIN = 4'h9;
  localparam logic [3:0] CW_MAX = 4'ha;
  localparam logic [9:0] LIT_LIM = 10'h100;
  localparam logic [9:0] CLEAR_CODE = 10'h100;
  localparam logic [9:0] EOF_CODE = 10'h101;
  localparam logic [10:0] FIRST_STR = 11'h102;
  localparam logic [10:0] TBL_END = 11'h400;
  localparam logic [4:0] BYTE_BITS = 5'h08;
  localparam logic [4:0] IN_ROOM = 5'h0a;

  typedef enum logic [11:0] {
    LZC_IDLE   = 12'h001,
    LZC_C_CLR  = 12'h002,
    LZC_C_GET  = 12'h004,
    LZC_C_SRCH = 12'h008,
    LZC_C_MISS = 12'h010,
    LZC_C_FULL = 12'h020,
    LZC_C_END  = 12'h040,
    LZC_C_EOF  = 12'h080,
    LZC_FLUSH  = 12'h100,
    LZC_E_GET  = 12'h200,
    LZC_E_WALK = 12'h400,
    LZC_E_POP  = 12'h800
  } lzc_state_t;

endpackage

`default_nettype wire

// ---- design/lzc_codec.sv ----
// LZW codec: byte stream in, byte stream out; mode selects compress or expand.
// Assumes in_data is synchronous to clk and that the sink may stall out_ready freely.

`default_nettype none

module lzc_codec (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic mode,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  output logic in_ready,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  output logic busy
);

  lzc_pkg::lzc_state_t state_q;
  logic mode_q;
  logic busy_q;
  logic first_q;
  logic last_q;
  logic [3:0] w_q;
  logic [10:0] next_q;
  logic [10:0] sidx_q;
  logic [9:0] base_q;
  logic [9:0] cur_q;
  logic [9:0] code_q;
  logic [7:0] sym_q;
  logic [7:0] fsym_q;
  logic [10:0] sp_q;

  logic [9:0] pre_mem [lzc_pkg::TBL_DEPTH];
  logic [7:0] suf_mem [lzc_pkg::TBL_DEPTH];
  logic [7:0] stk_mem [lzc_pkg::STK_DEPTH];

  logic [17:0] ibuf_q;
  logic [4:0] icnt_q;
  logic ilast_q;
  logic in_ready_q;
  logic [17:0] acc_q;
  logic [4:0] cnt_q;
  logic [7:0] head_q;
  logic head_v_q;
  logic [7:0] spare_q;
  logic spare_v_q;

  logic [10:0] cap;
  logic [9:0] mask;
  logic [4:0] take_len;
  logic take_go;
  logic [9:0] take_val;
  logic take_last;
  logic in_acc;
  logic [17:0] ib_nx;
  logic [4:0] ic_nx;
  logic emit_want;
  logic emit_go;
  logic [9:0] emit_val;
  logic [4:0] emit_len;
  logic pk_push;
  logic [7:0] pk_byte;
  logic hit;
  logic special;
  logic tbl_we;
  logic [9:0] tbl_pre;
  logic [7:0] tbl_suf;
  logic stk_we;
  logic [9:0] stk_idx;
  logic [7:0] stk_val;

  always_comb begin
    cap = 11'h001 << w_q;
    mask = 10'((11'h001 << w_q) - 11'h001);
    // Width of the next item taken is the current code width when expanding, a byte when compressing
    take_len = mode_q ? {1'b0, w_q} : lzc_pkg::BYTE_BITS;
    take_go = (state_q == lzc_pkg::LZC_C_GET || state_q == lzc_pkg::LZC_E_GET)
              && (icnt_q >= take_len);
    take_val = mode_q ? (ibuf_q[9:0] & mask) : {2'b00, ibuf_q[7:0]};
    take_last = ilast_q && (icnt_q == lzc_pkg::BYTE_BITS);
    in_acc = in_valid && in_ready_q;
    ib_nx = take_go ? (ibuf_q >> take_len) : ibuf_q;
    ic_nx = take_go ? (icnt_q - take_len) : icnt_q;
    if (in_acc) begin
      ib_nx = ib_nx | ({10'h000, in_data} << ic_nx);
      ic_nx = ic_nx + lzc_pkg::BYTE_BITS;
    end
    emit_want = 1'b1;
    emit_len = {1'b0, w_q};
    emit_val = base_q;
    case (state_q)
      lzc_pkg::LZC_C_CLR, lzc_pkg::LZC_C_FULL: emit_val = lzc_pkg::CLEAR_CODE;
      lzc_pkg::LZC_C_EOF: emit_val = lzc_pkg::EOF_CODE;
      lzc_pkg::LZC_C_MISS, lzc_pkg::LZC_C_END: emit_val = base_q;
      lzc_pkg::LZC_E_POP: begin
        emit_val = {2'b00, stk_mem[10'(sp_q - 11'h001)]};
        emit_len = lzc_pkg::BYTE_BITS;
      end
      default: emit_want = 1'b0;
    endcase
    emit_go = emit_want && (cnt_q < lzc_pkg::BYTE_BITS);
    pk_push = (cnt_q >= lzc_pkg::BYTE_BITS || (state_q == lzc_pkg::LZC_FLUSH && cnt_q != 5'h00))
              && !spare_v_q;
    pk_byte = acc_q[7:0];
    hit = (pre_mem[sidx_q[9:0]] == base_q) && (suf_mem[sidx_q[9:0]] == sym_q);
    special = !first_q && ({1'b0, take_val} >= next_q);
    tbl_we = 1'b0;
    tbl_pre = base_q;
    tbl_suf = sym_q;
    stk_we = 1'b0;
    stk_idx = sp_q[9:0];
    stk_val = fsym_q;
    if (state_q == lzc_pkg::LZC_C_MISS && emit_go) begin
      tbl_we = 1'b1;
    end
    if (state_q == lzc_pkg::LZC_E_GET && take_go && special
        && take_val != lzc_pkg::CLEAR_CODE && take_val != lzc_pkg::EOF_CODE) begin
      // The repeated first symbol is output last, so it sits at the stack bottom
      stk_we = 1'b1;
      stk_idx = 10'h000;
    end
    if (state_q == lzc_pkg::LZC_E_WALK) begin
      stk_we = 1'b1;
      stk_val = (cur_q >= lzc_pkg::LIT_LIM) ? suf_mem[cur_q] : cur_q[7:0];
      if (cur_q < lzc_pkg::LIT_LIM && !first_q && next_q < lzc_pkg::TBL_END) begin
        tbl_we = 1'b1;
        tbl_suf = cur_q[7:0];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (tbl_we) begin
      pre_mem[next_q[9:0]] <= tbl_pre;
      suf_mem[next_q[9:0]] <= tbl_suf;
    end
  end

  always_ff @(posedge clk) begin
    if (stk_we) begin
      stk_mem[stk_idx] <= stk_val;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= lzc_pkg::LZC_IDLE;
      mode_q <= 1'b0;
      busy_q <= 1'b0;
      first_q <= 1'b1;
      last_q <= 1'b0;
      w_q <= lzc_pkg::CW_MIN;
      next_q <= lzc_pkg::FIRST_STR;
      sidx_q <= lzc_pkg::FIRST_STR;
      base_q <= 10'h000;
      cur_q <= 10'h000;
      code_q <= 10'h000;
      sym_q <= 8'h00;
      fsym_q <= 8'h00;
      sp_q <= 11'h000;
    end else begin
      case (state_q)
        lzc_pkg::LZC_IDLE: begin
          if (start) begin
            // Literal-only table at 9 bits; strings start above 257
            mode_q <= mode;
            busy_q <= 1'b1;
            first_q <= 1'b1;
            last_q <= 1'b0;
            w_q <= lzc_pkg::CW_MIN;
            next_q <= lzc_pkg::FIRST_STR;
            state_q <= mode ? lzc_pkg::LZC_E_GET : lzc_pkg::LZC_C_CLR;
          end
        end
        lzc_pkg::LZC_C_CLR: begin
          if (emit_go) begin
            state_q <= lzc_pkg::LZC_C_GET;
          end
        end
        lzc_pkg::LZC_C_GET: begin
          if (take_go) begin
            last_q <= take_last;
            if (first_q) begin
              // First symbol only seeds the base; lookup waits for the second
              base_q <= take_val;
              first_q <= 1'b0;
              state_q <= take_last ? lzc_pkg::LZC_C_END : lzc_pkg::LZC_C_GET;
            end else begin
              sym_q <= take_val[7:0];
              sidx_q <= lzc_pkg::FIRST_STR;
              state_q <= lzc_pkg::LZC_C_SRCH;
            end
          end
        end
        lzc_pkg::LZC_C_SRCH: begin
          // One entry per cycle; only entries below next_q are live, so stale words are ignored
          if (sidx_q == next_q) begin
            state_q <= lzc_pkg::LZC_C_MISS;
          end else if (hit) begin
            base_q <= sidx_q[9:0];
            state_q <= last_q ? lzc_pkg::LZC_C_END : lzc_pkg::LZC_C_GET;
          end else begin
            sidx_q <= sidx_q + 11'h001;
          end
        end
        lzc_pkg::LZC_C_MISS: begin
          if (emit_go) begin
            next_q <= next_q + 11'h001;
            base_q <= {2'b00, sym_q};
            if (next_q + 11'h001 == lzc_pkg::TBL_END) begin
              state_q <= lzc_pkg::LZC_C_FULL;
            end else begin
              if (next_q + 11'h001 == cap && w_q != lzc_pkg::CW_MAX) begin
                w_q <= w_q + 4'h1;
              end
              state_q <= last_q ? lzc_pkg::LZC_C_END : lzc_pkg::LZC_C_GET;
            end
          end
        end
        lzc_pkg::LZC_C_FULL: begin
          if (emit_go) begin
            // Clear goes out at the full width, then both ends drop to 9 bits
            w_q <= lzc_pkg::CW_MIN;
            next_q <= lzc_pkg::FIRST_STR;
            state_q <= last_q ? lzc_pkg::LZC_C_END : lzc_pkg::LZC_C_GET;
          end
        end
        lzc_pkg::LZC_C_END: begin
          if (emit_go) begin
            state_q <= lzc_pkg::LZC_C_EOF;
          end
        end
        lzc_pkg::LZC_C_EOF: begin
          if (emit_go) begin
            state_q <= lzc_pkg::LZC_FLUSH;
          end
        end
        lzc_pkg::LZC_FLUSH: begin
          if (cnt_q == 5'h00) begin
            busy_q <= 1'b0;
            state_q <= lzc_pkg::LZC_IDLE;
          end
        end
        lzc_pkg::LZC_E_GET: begin
          if (take_go) begin
            if (take_val == lzc_pkg::CLEAR_CODE) begin
              first_q <= 1'b1;
              w_q <= lzc_pkg::CW_MIN;
              next_q <= lzc_pkg::FIRST_STR;
            end else if (take_val == lzc_pkg::EOF_CODE) begin
              busy_q <= 1'b0;
              state_q <= lzc_pkg::LZC_IDLE;
            end else begin
              code_q <= take_val;
              // An undefined code unwinds the previous string instead
              cur_q <= special ? base_q : take_val;
              sp_q <= special ? 11'h001 : 11'h000;
              state_q <= lzc_pkg::LZC_E_WALK;
            end
          end
        end
        lzc_pkg::LZC_E_WALK: begin
          sp_q <= sp_q + 11'h001;
          if (cur_q >= lzc_pkg::LIT_LIM) begin
            cur_q <= pre_mem[cur_q];
          end else begin
            // First code after a clear adds nothing; it only becomes the base
            if (!first_q && next_q < lzc_pkg::TBL_END) begin
              next_q <= next_q + 11'h001;
              // The table here lags the sender's by one entry, so widen one step early
              if (next_q + 11'h002 == cap && w_q != lzc_pkg::CW_MAX) begin
                w_q <= w_q + 4'h1;
              end
            end
            base_q <= code_q;
            fsym_q <= cur_q[7:0];
            first_q <= 1'b0;
            state_q <= lzc_pkg::LZC_E_POP;
          end
        end
        lzc_pkg::LZC_E_POP: begin
          if (emit_go) begin
            sp_q <= sp_q - 11'h001;
            if (sp_q == 11'h001) begin
              state_q <= lzc_pkg::LZC_E_GET;
            end
          end
        end
        default: begin
          busy_q <= 1'b0;
          state_q <= lzc_pkg::LZC_IDLE;
        end
      endcase
    end
  end

  // Input unpacker: bytes in, LSB first, items of take_len bits out
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ibuf_q <= 18'h00000;
      icnt_q <= 5'h00;
      ilast_q <= 1'b0;
      in_ready_q <= 1'b0;
    end else if (state_q == lzc_pkg::LZC_IDLE && start) begin
      ibuf_q <= 18'h00000;
      icnt_q <= 5'h00;
      ilast_q <= 1'b0;
      in_ready_q <= 1'b0;
    end else begin
      ibuf_q <= ib_nx;
      icnt_q <= ic_nx;
      if (in_acc && in_last) begin
        ilast_q <= 1'b1;
      end
      // Stop taking bytes once the last one is in, so end of input is unambiguous
      in_ready_q <= (state_q != lzc_pkg::LZC_IDLE) && !ilast_q && !(in_acc && in_last)
                    && (ic_nx <= lzc_pkg::IN_ROOM);
    end
  end

  // Output packer: codes in at the current width, expanded symbols at 8 bits, bytes out, zero pad on flush
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      acc_q <= 18'h00000;
      cnt_q <= 5'h00;
    end else if (emit_go) begin
      acc_q <= acc_q | ({8'h00, emit_val & ((emit_len == lzc_pkg::BYTE_BITS) ? 10'h0ff : mask)}
               << cnt_q);
      cnt_q <= cnt_q + emit_len;
    end else if (pk_push) begin
      acc_q <= acc_q >> lzc_pkg::BYTE_BITS;
      cnt_q <= (cnt_q >= lzc_pkg::BYTE_BITS) ? (cnt_q - lzc_pkg::BYTE_BITS) : 5'h00;
    end
  end

  // Two-entry output buffer; a full spare stalls the packer and, through it, the codec
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      head_q <= 8'h00;
      head_v_q <= 1'b0;
      spare_q <= 8'h00;
      spare_v_q <= 1'b0;
    end else if (!head_v_q || out_ready) begin
      if (spare_v_q) begin
        head_q <= spare_q;
        head_v_q <= 1'b1;
        spare_q <= pk_byte;
        spare_v_q <= pk_push;
      end else begin
        head_q <= pk_byte;
        head_v_q <= pk_push;
      end
    end else if (pk_push) begin
      spare_q <= pk_byte;
      spare_v_q <= 1'b1;
    end
  end

  assign in_ready = in_ready_q;
  assign out_valid = head_v_q;
  assign out_data = head_q;
  assign busy = busy_q;

endmodule

`default_nettype wire

// ---- verif/lzc_codec_chk.sv ----
// Checker: stream handshakes, start and idle behaviour of the codec ports.
// Assumes it is bound to lzc_codec and sees nothing but its ports.
`default_nettype none
module lzc_codec_chk (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic mode,
  input wire logic in_valid,
  input wire logic [7:0] in_data,
  input wire logic in_last,
  input wire logic in_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_ready,
  input wire logic busy
);
  // High until the first byte of a compress job is taken
  logic first_q;
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      first_q <= 1'b0;
    end else if (start && !busy && !mode && !out_valid) begin
      first_q <= 1'b1;
    end else if (out_valid && out_ready) begin
      first_q <= 1'b0;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_rst; $rose(rst_n) |-> !busy && !out_valid && !in_ready && out_data == 8'h00;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
  property p_start; start && !busy |=> busy; endproperty
  a_start: assert property (p_start) else $error("start not taken");
  property p_rdy; start && !busy |=> !in_ready; endproperty
  a_rdy: assert property (p_rdy) else $error("input open right after start");
  property p_hold; out_valid && !out_ready |=> out_valid && $stable(out_data); endproperty
  a_hold: assert property (p_hold) else $error("output byte lost in stall");
  property p_fell; $fell(out_valid) |-> $past(out_ready); endproperty
  a_fell: assert property (p_fell) else $error("output dropped untaken");
  property p_last; in_valid && in_ready && in_last |=> !in_ready; endproperty
  a_last: assert property (p_last) else $error("input taken after last");
  property p_clear; first_q && out_valid |-> out_data == 8'h00; endproperty
  a_clear: assert property (p_clear) else $error("first code is not clear");
  property p_idle; !busy && !start |=> !busy; endproperty
  a_idle: assert property (p_idle) else $error("busy without start");
  property p_noin; !busy [*3] |-> !in_ready; endproperty
  a_noin: assert property (p_noin) else $error("input open while idle");
  c_comp: cover property (start && !busy && !mode);
  c_exp: cover property (start && !busy && mode);
  c_stall: cover property (out_valid && !out_ready);
endmodule
bind lzc_codec lzc_codec_chk i_chk (.clk(clk), .rst_n(rst_n), .start(start), .mode(mode),
  .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready),
  .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .busy(busy));
`default_nettype wire

// ---- verif/lzc_sink.sv ----
// Sink model: takes output bytes, stalling three cycles in four when slow is set.
// Assumes the bench reads and empties got between jobs.
`default_nettype none
module lzc_sink (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic slow,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] cnt_q;
  logic [7:0] got[$];
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      out_ready <= 1'b0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      out_ready <= !slow || cnt_q == 2'h3;
      if (out_valid && out_ready) begin
        got.push_back(out_data);
      end
    end
  end
endmodule
`default_nettype wire

// ---- verif/test_lzc_string_table_codec.sv ----
// Bench: compress and expand jobs through a stalling sink, byte streams compared.
// Assumes pack() only sees 9-bit codes; the widening job is judged by size and round trip.
`default_nettype none
module test_lzc_string_table_codec;
  timeunit 1ns;
  timeprecision 1ps;
  typedef logic [7:0] lzc_bq_t[$];
  typedef logic [9:0] lzc_cq_t[$];
  logic clk, rst_n, start, mode, in_valid, in_last, in_ready;
  logic out_valid, out_ready, busy, slow;
  logic [7:0] in_data, out_data;
  int n_errors, comparisons;
  `define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin n_errors++; \
    $display("mismatch %0t value differs", $time); end end
  lzc_codec i_dut (.clk(clk), .rst_n(rst_n), .start(start), .mode(mode),
    .in_valid(in_valid), .in_data(in_data), .in_last(in_last), .in_ready(in_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready), .busy(busy));
  lzc_sink i_sink (.clk(clk), .rst_n(rst_n), .slow(slow), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Codes packed LSB first at 9 bits, last byte zero padded
  function automatic lzc_bq_t pack(input lzc_cq_t c);
    logic [31:0] acc;
    int n;
    lzc_bq_t b;
    acc = 32'h0;
    n = 0;
    foreach (c[i]) begin
      acc = acc | ({22'h0, c[i]} << n);
      n += 9;
      while (n >= 8) begin
        b.push_back(acc[7:0]);
        acc = acc >> 8;
        n -= 8;
      end
    end
    if (n > 0) begin
      b.push_back(acc[7:0]);
    end
    return b;
  endfunction
  task automatic run(input logic m, input lzc_bq_t d);
    int w;
    logic ok;
    ok = 1'b1;
    i_sink.got.delete();
    start <= 1'b1;
    mode <= m;
    @(posedge clk);
    start <= 1'b0;
    foreach (d[i]) begin
      in_valid <= 1'b1;
      in_data <= d[i];
      in_last <= (i == d.size() - 1);
      w = 0;
      do begin
        @(posedge clk);
        w++;
      end while (!in_ready && w < 5000);
      // A byte that was never taken counts against the job
      if (!in_ready) begin
        ok = 1'b0;
      end
    end
    in_valid <= 1'b0;
    in_last <= 1'b0;
    w = 0;
    while ((busy || out_valid) && w < 20000) begin
      @(posedge clk);
      w++;
    end
    repeat (4) @(posedge clk);
    `CHK(w < 20000 && ok, 1'b1)
  endtask
  task automatic expect_out(input lzc_bq_t e);
    `CHK(i_sink.got.size(), e.size())
    foreach (e[i]) begin
      if (i < i_sink.got.size()) `CHK(i_sink.got[i], e[i])
    end
  endtask
  task automatic t_reset();
    `CHK({busy, in_ready, out_valid}, 3'h0)
  endtask
  task automatic t_comp_pair();
    run(1'b0, '{8'h61, 8'h62});
    expect_out(pack('{10'h100, 10'h061, 10'h062, 10'h101}));
  endtask
  // Repeat hit on entry 258, then the result is expanded again
  task automatic t_comp_hit();
    lzc_bq_t c;
    slow <= 1'b1;
    run(1'b0, '{8'h61, 8'h62, 8'h61, 8'h62});
    expect_out(pack('{10'h100, 10'h061, 10'h062, 10'h102, 10'h101}));
    c = i_sink.got;
    run(1'b1, c);
    expect_out('{8'h61, 8'h62, 8'h61, 8'h62});
  endtask
  // Code 260 is not yet defined: previous string plus its first symbol
  task automatic t_exp_special();
    run(1'b1, pack('{10'h100, 10'h061, 10'h062, 10'h102, 10'h104, 10'h101}));
    expect_out('{8'h61, 8'h62, 8'h61, 8'h62, 8'h61, 8'h62, 8'h61});
  endtask
  // Clear mid-stream: 258 is rebuilt from the new symbols
  task automatic t_exp_clear();
    slow <= 1'b0;
    run(1'b1, pack('{10'h100, 10'h061, 10'h062, 10'h100, 10'h063, 10'h064, 10'h102,
      10'h101}));
    expect_out('{8'h61, 8'h62, 8'h63, 8'h64, 8'h63, 8'h64});
  endtask
  // Symbols 0..255 are all new pairs: entry 511 is written and the last three codes
  // go out at 10 bits, so 2325 bits in 291 bytes, end-of-file leaving 0x08 in the last
  task automatic t_widen();
    lzc_bq_t d;
    lzc_bq_t c;
    for (int i = 0; i < 256; i++) begin
      d.push_back(8'(i));
    end
    run(1'b0, d);
    `CHK(i_sink.got.size(), 291)
    `CHK(i_sink.got[i_sink.got.size() - 1], 8'h08)
    c = i_sink.got;
    run(1'b1, c);
    expect_out(d);
  endtask
  task automatic print_verdict();
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    n_errors++;
    print_verdict();
  end
  initial begin
    rst_n = 1'b0;
    start = 1'b0;
    mode = 1'b0;
    in_valid = 1'b0;
    in_data = 8'h00;
    in_last = 1'b0;
    slow = 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_comp_pair();
    t_comp_hit();
    t_exp_special();
    t_exp_clear();
    t_widen();
    print_verdict();
  end
endmodule
`default_nettype wire
